// >>> core/usi_pkg.sv
/*
 * Constants shared by the universal serial two-wire shifter.
 * Assumes a 10 MHz system clock and a separately clocked serial link domain.
 */
package usi_pkg;

   localparam int          SYS_CLK_HZ         = 10_000_000;
   localparam int          SDA_DELAY_MIN_NS   = 50;
   localparam int          SDA_DELAY_MAX_NS   = 300;
   // least delay rounds up to whole cycles, never below one
   localparam int          SDA_DELAY_CYC_RAW  = (SDA_DELAY_MIN_NS * (SYS_CLK_HZ / 1_000_000)
                                                 + 999) / 1000;
   localparam int          SDA_DELAY_CYCLES   = (SDA_DELAY_CYC_RAW < 1) ? 1 : SDA_DELAY_CYC_RAW;
   // sda delay chain is sized for this link period; a faster link clock gives it more stages
   localparam int          LINK_CLK_NS        = 12;
   localparam int          SDA_DLY_STAGES     = SDA_DELAY_MIN_NS / LINK_CLK_NS + 1;

   localparam logic [7:0]  SHIFT_RESET        = 8'h00;
   localparam logic [3:0]  COUNT_RESET        = 4'h0;
   localparam logic [3:0]  COUNT_MAX          = 4'hF;
   localparam logic [3:0]  COUNT_ACK_PRELOAD  = 4'hE;
   localparam int          MSB_POS            = 7;

   // wire_mode field values
   localparam logic [1:0]  WM_OFF             = 2'h0;
   localparam logic [1:0]  WM_THREE           = 2'h1;
   localparam logic [1:0]  WM_TWO             = 2'h2;
   localparam logic [1:0]  WM_TWO_HOLD        = 2'h3;

   // clock_source field values
   localparam logic [1:0]  CS_SOFT            = 2'h0;
   localparam logic [1:0]  CS_TIMER           = 2'h1;
   localparam logic [1:0]  CS_EXT_POS         = 2'h2;
   localparam logic [1:0]  CS_EXT_NEG         = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_START = 3'b010,
      ST_BUSY  = 3'b100
   } bus_state_t;

endpackage

// >>> core/usi_start_detect.sv
/*
 * Start and stop condition detector on the serial link clock domain.
 * Assumes scl/sda arrive already synchronised to link_clk_i.
 */
module usi_start_detect
   import usi_pkg::*;
(
   // link clock and reset
   input  wire logic link_clk_i,
   input  wire logic rst_n_i,
   // line levels
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic enable_i,
   // event toggles for the system domain
   output logic      start_tgl_o,
   output logic      stop_tgl_o
);

   logic [SDA_DLY_STAGES-1:0] sda_dly_reg;
   logic                      sda_prev_reg;
   logic                      start_tgl_reg;
   logic                      stop_tgl_reg;

   // delayed sda copy lets scl be sampled cleanly at the sda edge
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_dly_reg  <= '1;
         sda_prev_reg <= 1'b1;
      end else begin
         sda_dly_reg  <= {sda_dly_reg[SDA_DLY_STAGES-2:0], sda_i};
         sda_prev_reg <= sda_dly_reg[SDA_DLY_STAGES-1];
      end
   end

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_tgl_reg <= 1'b0;
         stop_tgl_reg  <= 1'b0;
      end else if (enable_i && scl_i) begin // R16
         if (sda_prev_reg && !sda_dly_reg[SDA_DLY_STAGES-1]) begin
            start_tgl_reg <= ~start_tgl_reg; // R6 R15
         end
         if (!sda_prev_reg && sda_dly_reg[SDA_DLY_STAGES-1]) begin
            stop_tgl_reg <= ~stop_tgl_reg; // R25
         end
      end
   end

   assign start_tgl_o = start_tgl_reg;
   assign stop_tgl_o  = stop_tgl_reg;

endmodule

// >>> core/usi_shifter.sv
/*
 * Universal serial shifter: 8-bit shift register, 4-bit edge counter,
 * two-wire clock hold and start/stop detection.
 * Assumes software drives the control ports from the clk_i domain and the
 * serial pins are asynchronous; start detection runs on link_clk_i.
 */
// Summary of operation
// [R1] three-wire slave shifts on rising serial clock; read byte after wrap
// [R2] two-wire mode with no slew limiting and no input filtering
// [R3] the master makes the clock; only the slave uses clock hold
// [R4] two-wire use should select the falling-edge shift option
// [R5] master checks scl really rose after each released edge
// [R6] sda falling while scl high sets the start seen flag
// [R7] data output follows shift register msb, gated by direction bit
// [R8] after start, hold scl low from its fall until flag cleared
// [R9] slave samples sda into shift register on rising scl
// [R10] counter wraps after eight bits and scl is held low
// [R11] acknowledge by preloading counter to 14 before releasing scl
// [R12] direction bit decides which party drives sda
// [R13] any number of bytes follow until stop or repeated start
// [R14] a slave that cannot take more data leaves it unacknowledged
// [R15] detector samples a delayed copy of sda
// [R16] detector and hold active only in two-wire mode
// [R17] detector runs on the link clock, flag can wake the core
// [R18] serial clock must not exceed a quarter of the system clock
// [R19] counter counts both external edges and can wrap alone
// [R20] timer compare clocking extends the timer to twelve bits
// [R21] preload to maximum makes one edge act as an interrupt
// [R22] software strobe counts exactly like a real clock edge
// [R23] start flag cleared by writing one; releases start hold
// [R24] wrap flag set 15 to 0, cleared by one, releases hold
// [R25] two-wire stop flag set on stop, cleared by writing one
module usi_shifter
   import usi_pkg::*;
(
   // clocks and reset
   input  wire logic       clk_i,
   input  wire logic       link_clk_i,
   input  wire logic       rst_n_i,
   // control
   input  wire logic [1:0] wire_mode_i,
   input  wire logic [1:0] clock_source_i,
   input  wire logic       soft_clk_strobe_i,
   input  wire logic       toggle_strobe_i,
   input  wire logic       timer_match_i,
   input  wire logic       data_dir_i,
   input  wire logic       port_data_i,
   input  wire logic       clock_dir_i,
   input  wire logic       port_clock_i,
   // software access to shift data and counter
   input  wire logic       data_wr_i,
   input  wire logic [7:0] data_wdata_i,
   input  wire logic       count_wr_i,
   input  wire logic [3:0] count_wdata_i,
   input  wire logic       start_clr_i,
   input  wire logic       wrap_clr_i,
   input  wire logic       stop_clr_i,
   // serial pins
   input  wire logic       serial_clock_pin_i,
   input  wire logic       data_in_pin_i,
   output logic            serial_clock_pin_o,
   output logic            serial_clock_pin_oe_o,
   output logic            data_out_pin_o,
   output logic            data_out_pin_oe_o,
   output logic            sda_o,
   output logic            sda_oe_o,
   // status
   output logic [7:0]      shift_data_o,
   output logic [3:0]      count_o,
   output logic            start_seen_flag_o,
   output logic            counter_wrap_flag_o,
   output logic            stop_seen_flag_o,
   output logic            collision_o,
   output logic            wake_o
);

   logic        clk_meta_reg;
   logic        clk_sync_reg;
   logic        clk_prev_reg;
   logic        din_meta_reg;
   logic        din_sync_reg;
   logic        lscl_meta_reg;
   logic        lscl_sync_reg;
   logic        lsda_meta_reg;
   logic        lsda_sync_reg;
   logic        two_wire;
   logic        det_en_meta_reg;
   logic        det_en_sync_reg;
   logic        start_tgl;
   logic        stop_tgl;
   logic [2:0]  start_sync_reg;
   logic [2:0]  stop_sync_reg;
   logic        start_evt;
   logic        stop_evt;
   logic        rise;
   logic        fall;
   logic        shift_en;
   logic        count_en;
   logic        ext_src;
   logic [7:0]  shift_data_reg;
   logic [7:0]  shift_data_next;
   logic [3:0]  count_reg;
   logic [3:0]  count_next;
   logic        wrap;
   logic        start_seen_flag_reg;
   logic        counter_wrap_flag_reg;
   logic        stop_seen_flag_reg;
   logic        out_latch_reg;
   logic        hold_scl;
   bus_state_t  state_reg;
   bus_state_t  state_next;

   assign two_wire = wire_mode_i[1]; // R2

   // pin synchronisers, first stage read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_meta_reg <= 1'b1;
         clk_sync_reg <= 1'b1;
         clk_prev_reg <= 1'b1;
         din_meta_reg <= 1'b1;
         din_sync_reg <= 1'b1;
      end else begin
         clk_meta_reg <= serial_clock_pin_i;
         clk_sync_reg <= clk_meta_reg;
         clk_prev_reg <= clk_sync_reg;
         din_meta_reg <= data_in_pin_i;
         din_sync_reg <= din_meta_reg;
      end
   end

   // link-domain copies of the lines and the mode level
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lscl_meta_reg   <= 1'b1;
         lscl_sync_reg   <= 1'b1;
         lsda_meta_reg   <= 1'b1;
         lsda_sync_reg   <= 1'b1;
         det_en_meta_reg <= 1'b0;
         det_en_sync_reg <= 1'b0;
      end else begin
         lscl_meta_reg   <= serial_clock_pin_i;
         lscl_sync_reg   <= lscl_meta_reg;
         lsda_meta_reg   <= data_in_pin_i;
         lsda_sync_reg   <= lsda_meta_reg;
         det_en_meta_reg <= two_wire;
         det_en_sync_reg <= det_en_meta_reg;
      end
   end

   // detector lives on the link clock so it needs no system clock activity
   usi_start_detect u_detect ( // R17
      .link_clk_i  (link_clk_i),
      .rst_n_i     (rst_n_i),
      .scl_i       (lscl_sync_reg),
      .sda_i       (lsda_sync_reg),
      .enable_i    (det_en_sync_reg),
      .start_tgl_o (start_tgl),
      .stop_tgl_o  (stop_tgl)
   );

   // toggle crossings back into the system domain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_sync_reg <= 3'b000;
         stop_sync_reg  <= 3'b000;
      end else begin
         start_sync_reg <= {start_sync_reg[1:0], start_tgl};
         stop_sync_reg  <= {stop_sync_reg[1:0], stop_tgl};
      end
   end

   assign start_evt = start_sync_reg[2] ^ start_sync_reg[1];
   assign stop_evt  = stop_sync_reg[2] ^ stop_sync_reg[1];

   // clock source selection; external edges are only seen below fclk/4
   assign rise    = clk_sync_reg && !clk_prev_reg; // R18
   assign fall    = !clk_sync_reg && clk_prev_reg;
   assign ext_src = clock_source_i[1]; // R21

   always_comb begin
      shift_en = 1'b0;
      count_en = 1'b0;
      unique case (clock_source_i)
         CS_SOFT: begin
            shift_en = soft_clk_strobe_i; // R22
            count_en = soft_clk_strobe_i;
         end
         CS_TIMER: begin
            shift_en = timer_match_i; // R20
            count_en = timer_match_i;
         end
         CS_EXT_POS: begin
            shift_en = rise || (soft_clk_strobe_i && toggle_strobe_i); // R1 R9
            count_en = rise || fall || toggle_strobe_i; // R19
         end
         CS_EXT_NEG: begin
            shift_en = fall || (soft_clk_strobe_i && toggle_strobe_i); // R4
            count_en = rise || fall || toggle_strobe_i; // R19
         end
      endcase
   end

   // a write in the same cycle as a clock wins over the shift
   always_comb begin
      shift_data_next = shift_data_reg;
      if (data_wr_i) begin
         shift_data_next = data_wdata_i;
      end else if (shift_en) begin
         shift_data_next = {shift_data_reg[6:0], din_sync_reg}; // R9
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_data_reg <= SHIFT_RESET;
      end else begin
         shift_data_reg <= shift_data_next;
      end
   end

   assign wrap = count_en && (count_reg == COUNT_MAX) && !count_wr_i; // R24

   always_comb begin
      count_next = count_reg;
      if (count_wr_i) begin
         count_next = count_wdata_i; // R11 R21
      end else if (count_en) begin
         count_next = count_reg + 4'h1; // R10
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         counter_wrap_flag_reg <= 1'b0;
      end else if (wrap) begin
         counter_wrap_flag_reg <= 1'b1; // R24
      end else if (wrap_clr_i) begin
         counter_wrap_flag_reg <= 1'b0;
      end
   end

   // outside two-wire mode the start flag marks counter increments instead
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_seen_flag_reg <= 1'b0;
      end else if ((two_wire && start_evt) || (!two_wire && count_en)) begin
         start_seen_flag_reg <= 1'b1; // R6 R16
      end else if (start_clr_i) begin
         start_seen_flag_reg <= 1'b0; // R23
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_seen_flag_reg <= 1'b0;
      end else if (two_wire && stop_evt) begin
         stop_seen_flag_reg <= 1'b1; // R25
      end else if (stop_clr_i) begin
         stop_seen_flag_reg <= 1'b0;
      end
   end

   // start hold: armed by a start, engaged by the next scl fall
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (two_wire && start_evt) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            if (!start_seen_flag_reg || !two_wire) begin
               state_next = ST_IDLE;
            end else if (fall) begin
               state_next = ST_BUSY; // R8
            end
         end
         ST_BUSY: begin
            if (!start_seen_flag_reg || !two_wire) begin
               state_next = ST_IDLE; // R23
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // wrap hold only in the hold variant; bus carries on byte after byte
   assign hold_scl = two_wire && ((state_reg == ST_BUSY)
                     || (wire_mode_i == WM_TWO_HOLD && counter_wrap_flag_reg)); // R10 R13

   // output latch is open while scl is low and holds while scl is high for external clocks
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_latch_reg <= 1'b1;
      end else if (!ext_src || !clk_sync_reg) begin
         out_latch_reg <= shift_data_next[MSB_POS]; // R7
      end
   end

   // pin drivers; two-wire pins are open drain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_out_pin_o        <= 1'b0;
         data_out_pin_oe_o     <= 1'b0;
         sda_o                 <= 1'b0;
         sda_oe_o              <= 1'b0;
         serial_clock_pin_o    <= 1'b0;
         serial_clock_pin_oe_o <= 1'b0;
      end else begin
         data_out_pin_o        <= out_latch_reg;
         data_out_pin_oe_o     <= (wire_mode_i == WM_THREE) && data_dir_i;
         sda_o                 <= 1'b0;
         sda_oe_o              <= two_wire && data_dir_i
                                  && !(out_latch_reg && port_data_i); // R7 R11 R12
         serial_clock_pin_o    <= two_wire ? 1'b0 : port_clock_i;
         serial_clock_pin_oe_o <= two_wire ? (hold_scl || (clock_dir_i && !port_clock_i))
                                  : clock_dir_i; // R8 R10
      end
   end

   // status outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_data_o        <= SHIFT_RESET;
         count_o             <= COUNT_RESET;
         start_seen_flag_o   <= 1'b0;
         counter_wrap_flag_o <= 1'b0;
         stop_seen_flag_o    <= 1'b0;
         collision_o         <= 1'b0;
         wake_o              <= 1'b0;
      end else begin
         shift_data_o        <= shift_data_reg;
         count_o             <= count_reg;
         start_seen_flag_o   <= start_seen_flag_reg;
         counter_wrap_flag_o <= counter_wrap_flag_reg; // R1
         stop_seen_flag_o    <= stop_seen_flag_reg;
         collision_o         <= two_wire && (shift_data_reg[MSB_POS] != din_sync_reg);
         wake_o              <= start_seen_flag_reg && two_wire; // R17
      end
   end

endmodule

// >>> sim/usi_shifter_sva.sv
/*
 * Concurrent checks on the ports of the serial shifter top.
 * Assumes status and pin outputs lag their cause by one or two clk_i cycles.
 */
module usi_shifter_sva
   import usi_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // control
   input  wire logic [1:0] wire_mode_i,
   input  wire logic       data_dir_i,
   input  wire logic       clock_dir_i,
   input  wire logic       port_clock_i,
   input  wire logic       count_wr_i,
   input  wire logic       start_clr_i,
   input  wire logic       wrap_clr_i,
   input  wire logic       stop_clr_i,
   // watched outputs
   input  wire logic       serial_clock_pin_o,
   input  wire logic       serial_clock_pin_oe_o,
   input  wire logic       data_out_pin_oe_o,
   input  wire logic       sda_o,
   input  wire logic       sda_oe_o,
   input  wire logic [3:0] count_o,
   input  wire logic       start_seen_flag_o,
   input  wire logic       counter_wrap_flag_o,
   input  wire logic       stop_seen_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_WRAP_SETS_FLAG: assert property (
      ($past(count_o) == COUNT_MAX && count_o == COUNT_RESET && !$past(count_wr_i)
       && !$past(count_wr_i, 2)) |-> ##[0:1] counter_wrap_flag_o)
      else $error("wrap flag missing after counter wrap");
   AST_COUNT_STEP: assert property (
      (count_o != $past(count_o) && !$past(count_wr_i) && !$past(count_wr_i, 2))
      |-> count_o == 4'($past(count_o) + 4'h1))
      else $error("counter moved by other than one");
   AST_WRAP_CLEAR_ONLY: assert property (
      $fell(counter_wrap_flag_o) |-> ($past(wrap_clr_i) || $past(wrap_clr_i, 2)))
      else $error("wrap flag dropped without clear");
   AST_START_CLEAR_ONLY: assert property (
      $fell(start_seen_flag_o) |-> ($past(start_clr_i) || $past(start_clr_i, 2)))
      else $error("start flag dropped without clear");
   AST_STOP_CLEAR_ONLY: assert property (
      $fell(stop_seen_flag_o) |-> ($past(stop_clr_i) || $past(stop_clr_i, 2)))
      else $error("stop flag dropped without clear");
   AST_CLOCK_PIN_PASS: assert property (
      (!wire_mode_i[1] && $stable(wire_mode_i) && $stable(clock_dir_i)
       && $stable(port_clock_i))[*3]
      |-> (serial_clock_pin_oe_o == clock_dir_i && serial_clock_pin_o == port_clock_i))
      else $error("clock pin not following port outside two-wire");
   AST_SCL_HOLD_LOW: assert property (
      wire_mode_i[1] [*3] ##0 serial_clock_pin_oe_o |-> !serial_clock_pin_o)
      else $error("scl driven high in two-wire");
   AST_SDA_OPEN_DRAIN: assert property (sda_oe_o |-> !sda_o)
      else $error("sda driven high");
   AST_SDA_NEEDS_DIR: assert property (!data_dir_i [*3] |-> !sda_oe_o)
      else $error("sda driven with direction bit low");
   AST_SDA_ONLY_TWO_WIRE: assert property (!wire_mode_i[1] [*3] |-> !sda_oe_o)
      else $error("sda driven outside two-wire");
   AST_DO_ENABLE: assert property (
      (wire_mode_i == WM_THREE && data_dir_i)[*3] |-> data_out_pin_oe_o)
      else $error("data out not enabled in three-wire");

   cover property ($rose(counter_wrap_flag_o));
   cover property (wire_mode_i[1] && $rose(start_seen_flag_o));
   cover property ($rose(stop_seen_flag_o));
   cover property (wire_mode_i[1] && serial_clock_pin_oe_o);
endmodule

// >>> sim/usi_bus_master.sv
/*
 * Behavioural bus master that bit-bangs the serial clock and data lines.
 * Assumes the bench resolves both lines as open drain with pull-ups.
 */
module usi_bus_master (
   // resolved lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-downs, high pulls the line low
   output logic      scl_low_o,
   output logic      sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // five system cycles a level, well under a quarter of the system clock
   localparam int HALF_NS = 500;

   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   task automatic clk_low();
      scl_low_o = 1'b1;
      #(HALF_NS);
   endtask

   task automatic start_cond();
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
      #(HALF_NS);
      sda_low_o = 1'b1;
      #(2 * HALF_NS);
      scl_low_o = 1'b1;
      #(HALF_NS);
   endtask

   // a one releases sda so the slave may answer
   task automatic put_bit(input logic b, output logic rd, output logic ok);
      int i;
      sda_low_o = !b;
      #(HALF_NS);
      scl_low_o = 1'b0;
      i = 0;
      // a slave may stretch the clock; give up after a bounded wait
      while (scl_i !== 1'b1 && i < 30) begin
         #100;
         i++;
      end
      ok = (scl_i === 1'b1);
      #(HALF_NS);
      rd = sda_i;
      scl_low_o = 1'b1;
      #(HALF_NS);
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      #(HALF_NS);
      scl_low_o = 1'b0;
      #(HALF_NS);
      sda_low_o = 1'b0;
      #(HALF_NS);
   endtask
endmodule

// >>> sim/universal_serial_two_wire_shifter_bench.sv
/*
 * Self-checking bench for the serial shifter with a bus master model.
 * Assumes clk_i at 10 MHz and an unrelated 12 ns link clock.
 */
module universal_serial_two_wire_shifter_bench;
   import usi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0;
   logic [1:0] wire_mode_i = WM_OFF, clock_source_i = CS_SOFT;
   logic soft_clk_strobe_i = 1'b0, toggle_strobe_i = 1'b0, timer_match_i = 1'b0;
   logic data_dir_i = 1'b0, data_wr_i = 1'b0, count_wr_i = 1'b0;
   logic [7:0] data_wdata_i = 8'h00;
   logic [3:0] count_wdata_i = 4'h0;
   logic start_clr_i = 1'b0, wrap_clr_i = 1'b0, stop_clr_i = 1'b0;
   logic scl_o, scl_oe, do_o, do_oe, sda_o, sda_oe, start_f, wrap_f, stop_f;
   logic [7:0] shift_data;
   logic [3:0] count;
   logic scl_low, sda_low, scl_line, sda_line, rd, ok, coll, wake;
   int   num_errors = 0, tests_run = 0, cycles = 0;

   initial forever #50 clk_i = !clk_i;
   initial begin
      #3;
      forever #6 link_clk_i = !link_clk_i;
   end

   assign scl_line = !(scl_low || (scl_oe && !scl_o));
   assign sda_line = !(sda_low || (sda_oe && !sda_o));

   usi_bus_master m (.scl_i(scl_line), .sda_i(sda_line), .scl_low_o(scl_low),
                     .sda_low_o(sda_low));

   usi_shifter dut (
      .clk_i(clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
      .wire_mode_i(wire_mode_i), .clock_source_i(clock_source_i),
      .soft_clk_strobe_i(soft_clk_strobe_i), .toggle_strobe_i(toggle_strobe_i),
      .timer_match_i(timer_match_i), .data_dir_i(data_dir_i), .port_data_i(1'b1),
      .clock_dir_i(1'b0), .port_clock_i(1'b1), .data_wr_i(data_wr_i),
      .data_wdata_i(data_wdata_i), .count_wr_i(count_wr_i), .count_wdata_i(count_wdata_i),
      .start_clr_i(start_clr_i), .wrap_clr_i(wrap_clr_i), .stop_clr_i(stop_clr_i),
      .serial_clock_pin_i(scl_line), .data_in_pin_i(sda_line),
      .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe),
      .data_out_pin_o(do_o), .data_out_pin_oe_o(do_oe), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .shift_data_o(shift_data), .count_o(count), .start_seen_flag_o(start_f),
      .counter_wrap_flag_o(wrap_f), .stop_seen_flag_o(stop_f), .collision_o(coll),
      .wake_o(wake));

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic settle();
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic set_cfg(input logic [1:0] wm, input logic [1:0] cs, input logic dir);
      @(posedge clk_i);
      wire_mode_i <= wm;
      clock_source_i <= cs;
      data_dir_i <= dir;
   endtask

   task automatic wr_data(input logic [7:0] v);
      @(posedge clk_i);
      data_wr_i <= 1'b1;
      data_wdata_i <= v;
      @(posedge clk_i);
      data_wr_i <= 1'b0;
   endtask

   task automatic wr_count(input logic [3:0] v);
      @(posedge clk_i);
      count_wr_i <= 1'b1;
      count_wdata_i <= v;
      @(posedge clk_i);
      count_wr_i <= 1'b0;
   endtask

   task automatic clr(input logic s, input logic w, input logic p);
      @(posedge clk_i);
      {start_clr_i, wrap_clr_i, stop_clr_i} <= {s, w, p};
      @(posedge clk_i);
      {start_clr_i, wrap_clr_i, stop_clr_i} <= 3'b000;
   endtask

   // sel 0 software strobe, 1 toggle strobe, 2 timer match; n back to back
   task automatic pulse(input int sel, input int n);
      repeat (n) begin
         @(posedge clk_i);
         {timer_match_i, toggle_strobe_i, soft_clk_strobe_i} <= 3'(1 << sel);
      end
      @(posedge clk_i);
      {timer_match_i, toggle_strobe_i, soft_clk_strobe_i} <= 3'b000;
   endtask

   task automatic send_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         m.put_bit(v[i], rd, ok);
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      settle();
      chk("reset", 8'h00, {count, start_f, wrap_f, stop_f, 1'b0});
      chk("reset shift", SHIFT_RESET, shift_data);
      set_cfg(WM_THREE, CS_SOFT, 1'b1);
      wr_data(8'h80);
      settle();
      chk("do msb", 8'h03, {do_oe, do_o});
      wr_data(8'h7F);
      settle();
      chk("do msb", 8'h02, {do_oe, do_o});
      wr_count(COUNT_MAX);
      pulse(0, 1);
      settle();
      chk("soft wrap", 8'h03, {count, start_f, wrap_f});
      clr(1'b1, 1'b1, 1'b0);
      settle();
      chk("flags cleared", 8'h00, {start_f, wrap_f});
      set_cfg(WM_THREE, CS_TIMER, 1'b1);
      pulse(2, 5);
      settle();
      chk("timer count", 8'h05, count);
      m.clk_low();
      set_cfg(WM_THREE, CS_EXT_POS, 1'b0);
      wr_count(4'h0);
      clr(1'b1, 1'b1, 1'b0);
      send_byte(8'h3C);
      settle();
      chk("three-wire byte", 8'h3C, shift_data);
      chk("edge wrap", 8'h01, {count, wrap_f});
      clr(1'b0, 1'b1, 1'b0);
      pulse(1, 3);
      settle();
      chk("toggle count", 8'h03, count);
      set_cfg(WM_TWO_HOLD, CS_EXT_NEG, 1'b0);
      clr(1'b1, 1'b1, 1'b1);
      m.start_cond();
      settle();
      chk("start seen", 8'h03, {start_f, wake});
      chk("start hold", 8'h01, scl_oe);
      clr(1'b1, 1'b0, 1'b0);
      wr_count(4'h0);
      settle();
      chk("hold released", 8'h00, {start_f, scl_oe});
      send_byte(8'hA7);
      settle();
      chk("address", 8'hA7, shift_data);
      chk("address wrap hold", 8'h03, {wrap_f, scl_oe});
      set_cfg(WM_TWO_HOLD, CS_EXT_NEG, 1'b1);
      wr_data(8'h00);
      wr_count(COUNT_ACK_PRELOAD);
      clr(1'b0, 1'b1, 1'b0);
      m.put_bit(1'b1, rd, ok);
      chk("ack level", 8'h01, {rd, ok});
      settle();
      chk("ack wrap", 8'h01, {count, wrap_f});
      m.put_bit(1'b1, rd, ok);
      chk("stretched", 8'h00, ok);
      set_cfg(WM_TWO_HOLD, CS_EXT_NEG, 1'b0);
      wr_data(8'h3F);
      clr(1'b0, 1'b1, 1'b1);
      m.put_bit(1'b1, rd, ok);
      chk("nack", 8'h03, {rd, ok});
      m.stop_cond();
      settle();
      chk("stop seen", 8'h03, {stop_f, coll});
      clr(1'b0, 1'b0, 1'b1);
      settle();
      chk("stop cleared", 8'h00, stop_f);
      set_cfg(WM_OFF, CS_SOFT, 1'b0);
      clr(1'b1, 1'b1, 1'b1);
      m.start_cond();
      m.stop_cond();
      settle();
      chk("detector off", 8'h00, {start_f, stop_f, scl_oe});
      close_out();
   end
endmodule

bind usi_shifter usi_shifter_sva u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .wire_mode_i(wire_mode_i), .data_dir_i(data_dir_i),
   .clock_dir_i(clock_dir_i), .port_clock_i(port_clock_i), .count_wr_i(count_wr_i),
   .start_clr_i(start_clr_i), .wrap_clr_i(wrap_clr_i), .stop_clr_i(stop_clr_i),
   .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
   .data_out_pin_oe_o(data_out_pin_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .count_o(count_o), .start_seen_flag_o(start_seen_flag_o),
   .counter_wrap_flag_o(counter_wrap_flag_o), .stop_seen_flag_o(stop_seen_flag_o));
